// ==== design/dcw_pkg.sv ====
// package for the dma channel control word block
// assumes one 200 mhz clock and an apb register slave
package dcw_pkg;
  // ****************************************
  // register map (byte addresses on apb, one word apart, pending two words after count)
  // ****************************************
  localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
  localparam logic [7:0]  ADDR_SRC      = 8'h04;
  localparam logic [7:0]  ADDR_DST      = 8'h08;
  localparam logic [7:0]  ADDR_COUNT    = 8'h0C;
  localparam logic [7:0]  ADDR_PENDING  = 8'h14;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // ****************************************
  // control word fields
  // ****************************************
  localparam int POS_RUN   = 0;
  localparam int POS_MODE  = 1;
  localparam int POS_SB    = 4;
  localparam int POS_BURST = 5;
  localparam int POS_SIZE  = 6;
  localparam int POS_SRCD  = 8;
  localparam int POS_DSTD  = 10;
  localparam int POS_IE    = 12;
  localparam int POS_ACK   = 13;
  localparam int POS_BUSY  = 31;
  localparam logic [16:0] CONTROL_WMASK = 17'h1_FFFF;
  localparam int COUNT_W   = 24;
  localparam int BEATS     = 4;

  typedef enum logic [2:0] {
    DCW_MODE_SW    = 3'h0,
    DCW_MODE_EXT   = 3'h1,
    DCW_MODE_SP_TX = 3'h2,
    DCW_MODE_SP_RX = 3'h3,
    DCW_MODE_CI_IN = 3'h4,
    DCW_MODE_CI_OUT= 3'h5
  } dcw_mode_t;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] DIR_INC   = 2'h0;
  localparam logic [1:0] DIR_DEC   = 2'h1;
  localparam logic [1:0] DIR_FIX   = 2'h2;

  typedef enum logic [2:0] {
    DCW_IDLE  = 3'b000,
    DCW_WAIT  = 3'b001,
    DCW_READ  = 3'b011,
    DCW_WRITE = 3'b010,
    DCW_ACK   = 3'b110
  } dcw_state_t;
endpackage

// ==== design/dcw_addr_step.sv ====
// one address stepper: moves an address by the transfer width
// assumes direction and width already validated by the caller
`timescale 1ns/1ps
module dcw_addr_step
  import dcw_pkg::*;
(
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_dir,
  input  wire logic [2:0]  i_width,
  input  wire logic        i_ignore,
  output logic      [31:0] o_addr
);
  always_comb begin
    o_addr = i_addr;
    if (!i_ignore) begin
      case (i_dir)
        DIR_INC: o_addr = i_addr + {29'h0, i_width};
        DIR_DEC: o_addr = i_addr - {29'h0, i_width};
        default: o_addr = i_addr;
      endcase
    end
  end
endmodule // dcw_addr_step

// ==== design/dcw_ack_timer.sv ====
// acknowledge pulse stretcher: holds ack for count plus one cycles
// assumes a one-cycle start pulse from the channel engine
`timescale 1ns/1ps
module dcw_ack_timer
  import dcw_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic [3:0] i_count,
  output logic            o_ack,
  output logic            o_done
);
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic       next_ack;
  logic       next_done;

  always_comb begin
    next_remain = remain;
    next_ack    = o_ack;
    next_done   = 1'b0;
    if (i_start) begin
      next_ack    = 1'b1;
      next_remain = i_count;
    end else if (o_ack) begin
      if (remain == 4'h0) begin
        next_ack  = 1'b0;
        next_done = 1'b1;
      end else begin
        next_remain = remain - 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      remain <= 4'h0;
      o_ack  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      remain <= next_remain;
      o_ack  <= next_ack;
      o_done <= next_done;
    end
  end
endmodule // dcw_ack_timer

// ==== design/dcw_channel.sv ====
// one dma channel: control word, addresses, count, pending flag, engine
// assumes apb master on i_clock; requester may be asynchronous (pin synchroniser), data ports on i_clock
`timescale 1ns/1ps
module dcw_channel
  import dcw_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_request,
  input  wire logic        i_mem_ready,
  input  wire logic [31:0] i_mem_rdata,
  output logic             o_mem_read,
  output logic             o_mem_write,
  output logic      [31:0] o_mem_addr,
  output logic      [31:0] o_mem_wdata,
  output logic      [1:0]  o_mem_size,
  output logic             o_ext_ack,
  output logic             o_irq
);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic req_meta;
  logic req_sync;
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= i_ext_request;
      req_sync <= req_meta;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic [16:0]        control;
  logic [31:0]        src_addr;
  logic [31:0]        dst_addr;
  logic [COUNT_W-1:0] count;
  logic               pending;
  logic               busy;
  dcw_state_t         state;
  logic [1:0]         beat;
  logic [31:0]        hold [BEATS];
  logic               block_go;
  logic               ack_start;

  logic [16:0]        next_control;
  logic [31:0]        next_src_addr;
  logic [31:0]        next_dst_addr;
  logic [COUNT_W-1:0] next_count;
  logic               next_pending;
  logic               next_busy;
  dcw_state_t         next_state;
  logic [1:0]         next_beat;
  logic [31:0]        next_hold [BEATS];
  logic               next_block_go;
  logic               next_ack_start;
  logic [31:0]        next_prdata;
  logic               next_pready;
  logic               next_pslverr;
  logic               next_mem_read;
  logic               next_mem_write;
  logic [31:0]        next_mem_addr;
  logic [31:0]        next_mem_wdata;

  // ****************************************
  // field decode
  // ****************************************
  logic       run_enable_bit;
  logic [2:0] mode;
  logic       single_block_select;
  logic       four_beat_burst_enable;
  logic [1:0] transfer_size_field;
  logic [1:0] source_direction_field;
  logic [1:0] destination_direction_field;
  logic       completion_interrupt_enable;
  logic [3:0] ack_cycle_count;
  logic [2:0] width;
  logic       src_ignore;
  logic       dst_ignore;
  logic       setting_ok;
  logic       use_burst;
  logic [COUNT_W-1:0] unit;
  logic       needs_request;
  logic [31:0] src_step;
  logic [31:0] dst_step;
  logic        ack_done;

  assign run_enable_bit              = control[POS_RUN];
  assign mode                        = control[POS_MODE +: 3];
  assign single_block_select         = control[POS_SB];
  assign four_beat_burst_enable      = control[POS_BURST];
  assign transfer_size_field         = control[POS_SIZE +: 2];
  assign source_direction_field      = control[POS_SRCD +: 2];
  assign destination_direction_field = control[POS_DSTD +: 2];
  assign completion_interrupt_enable = control[POS_IE];
  assign ack_cycle_count             = control[POS_ACK +: 4];

  always_comb begin
    case (transfer_size_field)
      SIZE_BYTE: width = 3'd1;
      SIZE_HALF: width = 3'd2;
      SIZE_WORD: width = 3'd4;
      default:   width = 3'd0;
    endcase
  end

  assign src_ignore = (mode == DCW_MODE_SP_RX) || (mode == DCW_MODE_CI_OUT);
  assign dst_ignore = (mode == DCW_MODE_SP_TX) || (mode == DCW_MODE_CI_IN);
  // a reserved encoding stalls the channel instead of guessing a width
  assign setting_ok = (mode <= 3'h5) && (width != 3'd0)
                   && (src_ignore || source_direction_field != 2'h3)
                   && (dst_ignore || destination_direction_field != 2'h3);
  // burst only while a whole four-beat unit remains
  assign use_burst  = four_beat_burst_enable
                   && (count >= {19'h0, width, 2'b00});
  assign unit       = use_burst ? {19'h0, width, 2'b00} : {21'h0, width};
  assign needs_request = (mode == DCW_MODE_EXT) && !block_go;

  dcw_addr_step u_src_step (
    .i_addr   (src_addr),
    .i_dir    (source_direction_field),
    .i_width  (width),
    .i_ignore (src_ignore),
    .o_addr   (src_step)
  );

  dcw_addr_step u_dst_step (
    .i_addr   (dst_addr),
    .i_dir    (destination_direction_field),
    .i_width  (width),
    .i_ignore (dst_ignore),
    .o_addr   (dst_step)
  );

  dcw_ack_timer u_ack (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_start  (ack_start),
    .i_count  (ack_cycle_count),
    .o_ack    (o_ext_ack),
    .o_done   (ack_done)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  logic apb_access;
  logic apb_wr;
  logic complete;
  assign apb_access = i_psel && i_penable && !o_pready;
  assign apb_wr     = apb_access && i_pwrite;

  always_comb begin
    next_control   = control;
    next_src_addr  = src_addr;
    next_dst_addr  = dst_addr;
    next_count     = count;
    next_pending   = pending;
    next_busy      = busy;
    next_state     = state;
    next_beat      = beat;
    next_hold      = hold;
    next_block_go  = block_go;
    next_ack_start = 1'b0;
    next_mem_read  = o_mem_read;
    next_mem_write = o_mem_write;
    next_mem_addr  = o_mem_addr;
    next_mem_wdata = o_mem_wdata;
    next_prdata    = o_prdata;
    next_pready    = apb_access;
    next_pslverr   = 1'b0;
    complete       = 1'b0;

    case (state)
      DCW_IDLE: begin
        if (run_enable_bit && setting_ok && count != '0) begin
          next_busy     = 1'b1;
          next_block_go = 1'b0;
          next_state    = DCW_WAIT;
        end
      end
      DCW_WAIT: begin
        if (count == '0) begin
          // a stop that lands on the last transfer still counts as a stop
          complete   = run_enable_bit;
          next_state = DCW_IDLE;
        end else if (!needs_request || req_sync) begin
          if (single_block_select) begin
            next_block_go = 1'b1;
          end
          next_beat     = 2'd0;
          next_mem_read = 1'b1;
          next_mem_addr = src_addr;
          next_state    = DCW_READ;
        end
      end
      DCW_READ: begin
        if (i_mem_ready) begin
          next_hold[beat] = i_mem_rdata;
          next_src_addr   = src_step;
          if (!use_burst || beat == 2'd3) begin
            next_mem_read  = 1'b0;
            next_mem_write = 1'b1;
            next_mem_addr  = dst_addr;
            next_mem_wdata = use_burst ? hold[0] : i_mem_rdata;
            next_beat      = 2'd0;
            next_state     = DCW_WRITE;
          end else begin
            next_mem_addr = src_step;
            next_beat     = beat + 2'd1;
          end
        end
      end
      DCW_WRITE: begin
        if (i_mem_ready) begin
          next_dst_addr = dst_step;
          if (!use_burst || beat == 2'd3) begin
            next_mem_write = 1'b0;
            next_count     = count - unit;
            if (mode == DCW_MODE_EXT) begin
              next_ack_start = 1'b1;
              next_state     = DCW_ACK;
            end else begin
              next_state = DCW_WAIT;
            end
          end else begin
            next_mem_addr  = dst_step;
            next_mem_wdata = hold[beat + 2'd1];
            next_beat      = beat + 2'd1;
          end
        end
      end
      DCW_ACK: begin
        if (ack_done) begin
          next_state = DCW_WAIT;
        end
      end
      default: next_state = DCW_IDLE;
    endcase

    if (complete) begin
      next_busy        = 1'b0;
      next_control[POS_RUN] = 1'b0;
      if (completion_interrupt_enable) begin
        next_pending = 1'b1;
      end
    end

    // software stop aborts quietly, finishing no pending flag
    if (state != DCW_IDLE && !run_enable_bit && !o_mem_read && !o_mem_write && !o_ext_ack) begin
      next_state    = DCW_IDLE;
      next_busy     = 1'b0;
      // cancel a read launched from the wait state in this same cycle
      next_mem_read = 1'b0;
    end

    if (apb_wr) begin
      case (i_paddr)
        ADDR_CONTROL: next_control = i_pwdata[16:0] & CONTROL_WMASK;
        ADDR_SRC:     next_src_addr = i_pwdata;
        ADDR_DST:     next_dst_addr = i_pwdata;
        ADDR_COUNT:   next_count    = i_pwdata[COUNT_W-1:0];
        ADDR_PENDING: next_pending  = (pending && !i_pwdata[0]) || (complete && completion_interrupt_enable);
        default:      next_pslverr  = 1'b1;
      endcase
    end else if (apb_access) begin
      case (i_paddr)
        ADDR_CONTROL: next_prdata = {busy, 14'h0, control};
        ADDR_SRC:     next_prdata = src_addr;
        ADDR_DST:     next_prdata = dst_addr;
        ADDR_COUNT:   next_prdata = {8'h0, count};
        ADDR_PENDING: next_prdata = {31'h0, pending};
        default: begin
          next_prdata  = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      control     <= CONTROL_RESET[16:0];
      src_addr    <= 32'h0000_0000;
      dst_addr    <= 32'h0000_0000;
      count       <= '0;
      pending     <= 1'b0;
      busy        <= 1'b0;
      state       <= DCW_IDLE;
      beat        <= 2'd0;
      hold        <= '{default: 32'h0000_0000};
      block_go    <= 1'b0;
      ack_start   <= 1'b0;
      o_prdata    <= 32'h0000_0000;
      o_pready    <= 1'b0;
      o_pslverr   <= 1'b0;
      o_mem_read  <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr  <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
      o_mem_size  <= 2'h0;
      o_irq       <= 1'b0;
    end else begin
      control     <= next_control;
      src_addr    <= next_src_addr;
      dst_addr    <= next_dst_addr;
      count       <= next_count;
      pending     <= next_pending;
      busy        <= next_busy;
      state       <= next_state;
      beat        <= next_beat;
      hold        <= next_hold;
      block_go    <= next_block_go;
      ack_start   <= next_ack_start;
      o_prdata    <= next_prdata;
      o_pready    <= next_pready;
      o_pslverr   <= next_pslverr;
      o_mem_read  <= next_mem_read;
      o_mem_write <= next_mem_write;
      o_mem_addr  <= next_mem_addr;
      o_mem_wdata <= next_mem_wdata;
      o_mem_size  <= transfer_size_field;
      o_irq       <= next_pending;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_IDLE_NOT_BUSY: assert property (@(posedge i_clock) disable iff (!i_resetn)
    busy == (state != DCW_IDLE)) else $error("busy while idle");
  AST_START_BUSY: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state == DCW_IDLE && next_state == DCW_WAIT) |=> busy) else $error("busy not set");
  AST_BAD_NO_XFER: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state == DCW_IDLE && !setting_ok) |=> state == DCW_IDLE) else $error("reserved setting ran");
  AST_NO_IRQ_ABORT: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state != DCW_IDLE && !run_enable_bit && !pending && !apb_wr) |=> !pending) else $error("irq on abort");
  AST_IE_OFF: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (!pending && !completion_interrupt_enable && !apb_wr) |=> !pending) else $error("irq with ie off");
  AST_COUNT_STEP: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state == DCW_WRITE && next_state != DCW_WRITE && !apb_wr) |=> count == $past(count) - $past(unit))
    else $error("count step wrong");
  AST_SRC_STEP: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state == DCW_READ && i_mem_ready && !src_ignore && source_direction_field == DIR_INC && !apb_wr)
    |=> src_addr == $past(src_addr) + {29'h0, $past(width)}) else $error("source step wrong");
  AST_ACK_LEN: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ($rose(o_ext_ack) && ack_cycle_count == 4'h1) |-> o_ext_ack [*2] ##1 !o_ext_ack) else $error("ack length");
endmodule // dcw_channel

// ==== verif/dcw_mem_model.sv ====
// memory side partner: answers read and write beats after a chosen stall
// assumes the channel holds each beat request until ready is seen high
`timescale 1ns/1ps
module dcw_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [3:0]  i_stall,
  output logic             o_ready,
  output logic      [31:0] o_rdata
);
  logic [3:0]  wait_cnt;
  logic [3:0]  next_wait_cnt;
  logic        next_ready;
  logic [31:0] next_rdata;

  always_comb begin
    next_wait_cnt = 4'h0;
    next_ready    = 1'b0;
    // data outside a read answer keeps toggling so a stale sample cannot match
    next_rdata    = ~o_rdata;
    if ((i_read || i_write) && !o_ready) begin
      if (wait_cnt >= i_stall) begin
        next_ready = 1'b1;
        if (i_read) begin
          next_rdata = i_addr ^ 32'h5A5A_0000;
        end
      end else begin
        next_wait_cnt = wait_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      wait_cnt <= 4'h0;
      o_ready  <= 1'b0;
      o_rdata  <= 32'h0000_0000;
    end else begin
      wait_cnt <= next_wait_cnt;
      o_ready  <= next_ready;
      o_rdata  <= next_rdata;
    end
  end
endmodule // dcw_mem_model

// ==== verif/dma_channel_control_word_bench.sv ====
// self-checking bench for one dma channel: apb master, memory partner, requester
// assumes the channel answers apb with one wait state and runs on one clock
`timescale 1ns/1ps
module dma_channel_control_word_bench;
  import dcw_pkg::*;
  logic        i_clock, i_resetn, i_psel, i_penable, i_pwrite, i_ext_request, i_mem_ready;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, i_mem_rdata, o_mem_addr, o_mem_wdata;
  logic        o_pready, o_pslverr, o_mem_read, o_mem_write, o_ext_ack, o_irq;
  logic [1:0]  o_mem_size;
  logic [3:0]  stall;
  int          miscompares, comparisons, cycles, ack_len;
  logic        q_kind[$];
  logic [31:0] q_addr[$];
  logic [31:0] q_data[$];
  logic [1:0]  q_size[$];
  int          q_ack[$];
  logic [31:0] d;
  logic        e;

  dcw_channel u_dcw_channel (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_request(i_ext_request),
    .i_mem_ready(i_mem_ready), .i_mem_rdata(i_mem_rdata), .o_mem_read(o_mem_read),
    .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_mem_size(o_mem_size), .o_ext_ack(o_ext_ack), .o_irq(o_irq));
  dcw_mem_model u_dcw_mem_model (.i_clock(i_clock), .i_resetn(i_resetn), .i_read(o_mem_read),
    .i_write(o_mem_write), .i_addr(o_mem_addr), .i_stall(stall), .o_ready(i_mem_ready),
    .o_rdata(i_mem_rdata));

  // ****************************************
  // clock, timeout and beat monitor
  // ****************************************
  always #2.5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
    if (i_resetn && (o_mem_read || o_mem_write) && i_mem_ready) begin
      q_kind.push_back(o_mem_write);
      q_addr.push_back(o_mem_addr);
      q_data.push_back(o_mem_write ? o_mem_wdata : i_mem_rdata);
      q_size.push_back(o_mem_size);
    end
    if (o_ext_ack === 1'b1) begin
      ack_len++;
    end else if (ack_len != 0) begin
      q_ack.push_back(ack_len);
      ack_len = 0;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    i_psel    <= 1'b1;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // o_pready seen high ends this wait; only the cycle timeout ends a hung one
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp);
  endtask

  function automatic logic [31:0] ctl(logic [2:0] mode, logic sb, logic fb, logic [1:0] sz,
                                      logic [1:0] sd, logic [1:0] dd, logic ie, logic [3:0] ack);
    return {15'h0, ack, ie, dd, sd, sz, fb, sb, mode, 1'b1};
  endfunction

  task automatic setup(input logic [31:0] src, input logic [31:0] dst, input logic [31:0] cnt);
    wr(ADDR_SRC, src);
    wr(ADDR_DST, dst);
    wr(ADDR_COUNT, cnt);
    q_kind.delete();
    q_addr.delete();
    q_data.delete();
    q_size.delete();
    q_ack.delete();
  endtask

  task automatic wait_idle();
    do begin
      apb(1'b0, ADDR_CONTROL, 32'h0, d, e);
    end while (d[POS_BUSY] !== 1'b0);
    repeat (20) @(posedge i_clock);
  endtask

  // addresses of one kind of beat, in order, against a base and a signed step
  task automatic chk_beats(input logic k, input logic [31:0] base, input int step, input int n);
    int j;
    j = 0;
    foreach (q_kind[i]) if (q_kind[i] === k) begin
      check(q_addr[i], base + 32'(j * step));
      j++;
    end
    check(32'(j), 32'(n));
  endtask

  task automatic pulse_request();
    i_ext_request <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_ext_request <= 1'b0;
    repeat (40) @(posedge i_clock);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk(ADDR_CONTROL, CONTROL_RESET);
    rd_chk(ADDR_COUNT, 32'h0000_0000);
    wr(ADDR_CONTROL, 32'hFFFF_FFFE);
    rd_chk(ADDR_CONTROL, 32'h0001_FFFE);
    wr(ADDR_CONTROL, 32'h0000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0, d, e);
    check({31'h0, e}, 32'h1);
    check(d, 32'h0000_0000);
    rd_chk(ADDR_CONTROL, 32'h0000_0000);
  endtask

  task automatic t_sizes();
    for (int s = 0; s < 3; s++) begin
      setup(32'h0000_0100, 32'h0000_0200, 32'(2 << s));
      wr(ADDR_CONTROL, ctl(DCW_MODE_SW, 1'b0, 1'b0, 2'(s), DIR_INC, DIR_FIX, 1'b0, 4'h0));
      wait_idle();
      chk_beats(1'b0, 32'h0000_0100, 1 << s, 2);
      chk_beats(1'b1, 32'h0000_0200, 0, 2);
      check({30'h0, q_size[0]}, 32'(s));
      check({31'h0, o_irq}, 32'h0);
      rd_chk(ADDR_COUNT, 32'h0000_0000);
    end
  endtask

  task automatic t_dirs_irq();
    stall <= 4'h8;
    setup(32'h0000_0400, 32'h0000_0800, 32'h0000_000C);
    wr(ADDR_CONTROL, ctl(DCW_MODE_SW, 1'b0, 1'b0, SIZE_WORD, DIR_DEC, DIR_INC, 1'b1, 4'h0));
    apb(1'b0, ADDR_CONTROL, 32'h0, d, e);
    check({31'h0, d[POS_BUSY]}, 32'h1);
    wait_idle();
    chk_beats(1'b0, 32'h0000_0400, -4, 3);
    chk_beats(1'b1, 32'h0000_0800, 4, 3);
    check(q_data[1], 32'h5A5A_0400);
    check({31'h0, o_irq}, 32'h1);
    rd_chk(ADDR_PENDING, 32'h0000_0001);
    wr(ADDR_PENDING, 32'h0000_0001);
    check({31'h0, o_irq}, 32'h0);
    stall <= 4'h1;
  endtask

  task automatic t_burst();
    logic [31:0] order;
    order = 32'h0;
    // burst keeps both directions incrementing, as software must
    setup(32'h0000_1000, 32'h0000_2000, 32'h0000_0014);
    wr(ADDR_CONTROL, ctl(DCW_MODE_SW, 1'b0, 1'b1, SIZE_WORD, DIR_INC, DIR_INC, 1'b0, 4'h0));
    wait_idle();
    foreach (q_kind[i]) order = {order[30:0], q_kind[i]};
    check(order, 32'h0000_003D);
    check(32'(q_kind.size()), 32'd10);
    chk_beats(1'b0, 32'h0000_1000, 4, 5);
    chk_beats(1'b1, 32'h0000_2000, 4, 5);
  endtask

  task automatic t_ext();
    setup(32'h0000_3000, 32'h0000_4000, 32'h0000_0008);
    wr(ADDR_CONTROL, ctl(DCW_MODE_EXT, 1'b0, 1'b0, SIZE_WORD, DIR_INC, DIR_INC, 1'b0, 4'h1));
    pulse_request();
    check(32'(q_kind.size()), 32'd2);
    pulse_request();
    wait_idle();
    check(32'(q_kind.size()), 32'd4);
    check(32'(q_ack[0]), 32'd2);
    // block handling is only chosen in external request mode
    setup(32'h0000_3000, 32'h0000_4000, 32'h0000_000C);
    wr(ADDR_CONTROL, ctl(DCW_MODE_EXT, 1'b1, 1'b0, SIZE_WORD, DIR_INC, DIR_INC, 1'b0, 4'hF));
    pulse_request();
    wait_idle();
    check(32'(q_kind.size()), 32'd6);
    check(32'(q_ack[2]), 32'd16);
  endtask

  task automatic t_serial();
    setup(32'h0000_5000, 32'h0000_6000, 32'h0000_0003);
    // serial modes run byte wide; the ignored field holds a reserved code
    wr(ADDR_CONTROL, ctl(DCW_MODE_SP_RX, 1'b0, 1'b0, SIZE_BYTE, 2'h3, DIR_INC, 1'b0, 4'h0));
    wait_idle();
    chk_beats(1'b1, 32'h0000_6000, 1, 3);
    setup(32'h0000_5000, 32'h0000_6000, 32'h0000_0003);
    wr(ADDR_CONTROL, ctl(DCW_MODE_SP_TX, 1'b0, 1'b0, SIZE_BYTE, DIR_INC, 2'h3, 1'b0, 4'h0));
    wait_idle();
    chk_beats(1'b0, 32'h0000_5000, 1, 3);
  endtask

  task automatic t_abort();
    stall <= 4'hF;
    setup(32'h0000_7000, 32'h0000_8000, 32'h0000_00C8);
    wr(ADDR_CONTROL, ctl(DCW_MODE_SW, 1'b0, 1'b0, SIZE_BYTE, DIR_INC, DIR_INC, 1'b1, 4'h0));
    repeat (20) @(posedge i_clock);
    wr(ADDR_CONTROL, ctl(DCW_MODE_SW, 1'b0, 1'b0, SIZE_BYTE, DIR_INC, DIR_INC, 1'b1, 4'h0) ^ 32'h1);
    wait_idle();
    check({31'h0, o_irq}, 32'h0);
    rd_chk(ADDR_PENDING, 32'h0000_0000);
    apb(1'b0, ADDR_COUNT, 32'h0, d, e);
    check({31'h0, d == 32'h0}, 32'h0);
    stall <= 4'h0;
  endtask

  task automatic t_reserved();
    logic [31:0] bad[5];
    bad = '{ctl(3'h6, 1'b0, 1'b0, SIZE_WORD, DIR_INC, DIR_INC, 1'b0, 4'h0),
            ctl(3'h7, 1'b0, 1'b0, SIZE_WORD, DIR_INC, DIR_INC, 1'b0, 4'h0),
            ctl(DCW_MODE_SW, 1'b0, 1'b0, 2'h3, DIR_INC, DIR_INC, 1'b0, 4'h0),
            ctl(DCW_MODE_SW, 1'b0, 1'b0, SIZE_WORD, 2'h3, DIR_INC, 1'b0, 4'h0),
            ctl(DCW_MODE_SW, 1'b0, 1'b0, SIZE_WORD, DIR_INC, 2'h3, 1'b0, 4'h0)};
    foreach (bad[i]) begin
      setup(32'h0000_9000, 32'h0000_A000, 32'h0000_0004);
      wr(ADDR_CONTROL, bad[i]);
      repeat (30) @(posedge i_clock);
      check(32'(q_kind.size()), 32'd0);
      apb(1'b0, ADDR_CONTROL, 32'h0, d, e);
      check({31'h0, d[POS_BUSY]}, 32'h0);
      wr(ADDR_CONTROL, 32'h0000_0000);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_clock = 1'b0;
    i_resetn = 1'b0;
    {i_psel, i_penable, i_pwrite, i_ext_request} = 4'h0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    stall = 4'h0;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    t_regs();
    t_sizes();
    t_dirs_irq();
    t_burst();
    t_ext();
    t_serial();
    t_abort();
    t_reserved();
    close_out();
  end
endmodule // dma_channel_control_word_bench
